// >>> cansp_pkg.sv
// package: register map, field layout, timing and carrier types of the signal packer
package cansp_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CANSP_CLK_NS    = 20;          // 50 MHz system clock
  localparam int CANSP_TICK_NS   = 1_000_000;   // timer tick of one millisecond
  localparam int CANSP_MS_CYCLES = (CANSP_TICK_NS + CANSP_CLK_NS - 1) / CANSP_CLK_NS;
  localparam int CANSP_HOLD_S    = 2;           // transmit hold-off after reset
  localparam int CANSP_HOLD_MS   = CANSP_HOLD_S * 1000;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int CANSP_NUM_TX  = 2;
  localparam int CANSP_SIG_PER = 4;
  localparam int CANSP_NUM_SIG = CANSP_NUM_TX * CANSP_SIG_PER;
  localparam int CANSP_NUM_RX  = 4;
  localparam int CANSP_NUM_K   = 6;             // programmable constants 3 to 8
  localparam int CANSP_NUM_ADD = 16;
  localparam logic [5:0] CANSP_FIELD_MAX = 6'h20;

  // ---------------------------------------------------------------
  // word indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] CANSP_IDX_TX_PER0  = 6'h00;
  localparam logic [5:0] CANSP_IDX_TX_GRP0  = 6'h01;
  localparam logic [5:0] CANSP_IDX_TX_PER1  = 6'h02;
  localparam logic [5:0] CANSP_IDX_TX_GRP1  = 6'h03;
  localparam logic [5:0] CANSP_IDX_SIG_BASE = 6'h04;  // cfg, scale pairs
  localparam logic [5:0] CANSP_IDX_K_BASE   = 6'h14;
  localparam logic [5:0] CANSP_IDX_STATUS   = 6'h1F;
  localparam logic [5:0] CANSP_IDX_RX_BASE  = 6'h20;  // eight words per slot
  localparam logic [2:0] CANSP_RX_CFG   = 3'h0;
  localparam logic [2:0] CANSP_RX_ID    = 3'h1;
  localparam logic [2:0] CANSP_RX_SCALE = 3'h2;
  localparam logic [2:0] CANSP_RX_TMO   = 3'h3;
  localparam logic [2:0] CANSP_RX_LIM   = 3'h4;
  localparam logic [2:0] CANSP_RX_VAL   = 3'h5;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CANSP_F_EN    = 0;
  localparam int CANSP_F_TYPE  = 0;   // 4 bits
  localparam int CANSP_F_IDX   = 4;   // 5 bits
  localparam int CANSP_F_SIZE  = 10;  // 6 bits
  localparam int CANSP_F_POS   = 20;  // 6 bits: byte index above bit index
  localparam int CANSP_F_OFF   = 0;   // 16 bits signed
  localparam int CANSP_F_RES   = 16;  // 16 bits, eight fraction bits
  localparam int CANSP_F_MIN   = 0;   // 16 bits signed
  localparam int CANSP_F_MAX   = 16;  // 16 bits signed
  localparam int CANSP_RES_FRAC = 8;
  localparam logic [31:0] CANSP_CFG_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // source type codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CANSP_SRC_UNUSED = 4'h0,
    CANSP_SRC_RX     = 4'h1,
    CANSP_SRC_UIN    = 4'h2,
    CANSP_SRC_CONST  = 4'h3,
    CANSP_SRC_SPEED  = 4'h4,
    CANSP_SRC_CURR   = 4'h5,
    CANSP_SRC_SUPPLY = 4'h6,
    CANSP_SRC_TEMP   = 4'h7,
    CANSP_SRC_TMO    = 4'h8,
    CANSP_SRC_ADD    = 4'h9,
    CANSP_SRC_PID    = 4'hA
  } cansp_src_e;

  // every value that a consumer may select
  typedef struct packed {
    logic [CANSP_NUM_RX-1:0][31:0]  rx;
    logic [3:0][31:0]               uin;
    logic [CANSP_NUM_K-1:0][31:0]   konst;
    logic [31:0]                    speed;
    logic [31:0]                    current;
    logic [31:0]                    supply;
    logic [31:0]                    temp;
    logic                           tmo;
    logic [CANSP_NUM_ADD-1:0][31:0] addl;
    logic [31:0]                    pid;
  } cansp_src_s;

  typedef logic [63:0][31:0] cansp_cfg_t;

  // words that software may write
  function automatic logic cansp_writable(input logic [5:0] i);
    return (i < CANSP_IDX_K_BASE + 6'h06) ||
           (i >= CANSP_IDX_RX_BASE && i[2:0] <= CANSP_RX_LIM);
  endfunction : cansp_writable

endpackage : cansp_pkg

// >>> cansp_sig_pack.sv
// module: source select, offset, scaling, saturation and placement of one transmit signal
`timescale 1ns/1ps
module cansp_sig_pack
  import cansp_pkg::*;
(
  // every selectable value
  input  cansp_src_s  src,
  // signal configuration
  input  logic [31:0] cfg_word,
  input  logic [31:0] scale_word,
  // field placed in the eight payload bytes
  output logic [63:0] field_bits
);

  logic [3:0]         typ;
  logic [4:0]         idx;
  logic [5:0]         size;
  logic [5:0]         pos;
  logic signed [31:0] v;
  logic signed [32:0] diff;
  logic signed [49:0] prod;
  logic signed [49:0] scaled;
  logic [31:0]        fmax;
  logic [31:0]        fval;

  assign typ  = cfg_word[CANSP_F_TYPE +: 4];
  assign idx  = cfg_word[CANSP_F_IDX +: 5];
  assign size = cfg_word[CANSP_F_SIZE +: 6];
  assign pos  = cfg_word[CANSP_F_POS +: 6];

  // source select; out-of-range indices give zero
  always_comb begin : sel
    v = '0;
    unique case (typ)
      CANSP_SRC_RX:     if (idx >= 5'h01 && idx <= 5'h04) v = src.rx[2'(idx - 5'h01)];
      CANSP_SRC_UIN:    if (idx >= 5'h01 && idx <= 5'h04) v = src.uin[2'(idx - 5'h01)];
      CANSP_SRC_CONST: begin
        if (idx == 5'h02) v = 32'h0000_0001;
        else if (idx >= 5'h03 && idx <= 5'h08) v = src.konst[3'(idx - 5'h03)];
      end
      CANSP_SRC_SPEED:  if (idx == 5'h01) v = src.speed;
      CANSP_SRC_CURR:   if (idx == 5'h01) v = src.current;
      CANSP_SRC_SUPPLY: if (idx == 5'h01) v = src.supply;
      CANSP_SRC_TEMP:   if (idx == 5'h01) v = src.temp;
      CANSP_SRC_TMO:    if (idx == 5'h01) v = {31'h0, src.tmo};
      CANSP_SRC_ADD:    if (idx >= 5'h01 && idx <= 5'h10) v = src.addl[4'(idx - 5'h01)];
      CANSP_SRC_PID:    if (idx == 5'h01) v = src.pid;
      default:          v = '0;   // unused or undefined code
    endcase
  end

  // offset first, then resolution with eight fraction bits
  assign diff   = 33'(v) - 33'($signed(scale_word[CANSP_F_OFF +: 16]));
  assign prod   = diff * $signed({1'b0, scale_word[CANSP_F_RES +: 16]});
  assign scaled = prod >>> CANSP_RES_FRAC;

  // saturate instead of wrapping; negative results pin at zero
  assign fmax = (size >= CANSP_FIELD_MAX) ? 32'hFFFF_FFFF :
                32'((33'h0_0000_0001 << size) - 33'h0_0000_0001);
  assign fval = (scaled < 50'sh0) ? 32'h0 :
                (scaled > $signed({18'h0, fmax})) ? fmax : scaled[31:0];

  // lsb at byte*8+bit; bits past byte eight fall off the shift
  assign field_bits = (typ == CANSP_SRC_UNUSED || size == 6'h00) ? 64'h0 :
                      (64'(fval) << pos);

endmodule : cansp_sig_pack

// >>> cansp_frame_map.sv
// module: top of the transmit/receive signal packer with its register port
//
// Functional notes
// - Each transmit message carries four signals, each with source type and index.
// - Source type zero disables the signal; its other settings are ignored.
// - A transmit field is as many bits wide as its size setting, at most 32.
// - The byte-index setting picks which of eight bytes holds the lsb.
// - The bit-index setting picks which of eight bits holds the lsb.
// - Transmit value is source minus offset, then scaled by resolution.
// - Receive slots start disabled and stay idle until enabled.
// - An enabled slot raises link loss when no frame arrives within timeout.
// - A timeout of zero turns supervision off; no link loss then.
// - Received field extracted by size and position, then resolution and offset.
// - Min and max bound the received value and act as off/on thresholds.
// - Threshold compare uses the scaled value, not the raw field.
// - Four independent receive slots with own id, mapping, timeout, limits.
// - Codes 1 rx 1-4, 2 input 1-4, 3 constant 1-8, 9 extra 1-16.
// - Codes 4 to 8 and 10 are single sources with index one.
// - Constant 1 is false, 2 true, 3 to 8 programmable, no limits.
// - Every source is selectable by every consumer.
// - Two messages; period zero disables unless the group is shared.
// - No transmission until two seconds after reset.
`timescale 1ns/1ps
module cansp_frame_map
  import cansp_pkg::*;
#(
  parameter int MS_CYCLES = CANSP_MS_CYCLES,
  parameter int HOLD_MS   = CANSP_HOLD_MS
) (
  // clock and reset
  input  logic                           mclk,
  input  logic                           rst,
  // register port
  input  logic [7:0]                     bus_addr,
  input  logic [31:0]                    bus_wdata,
  input  logic                           bus_wr,
  input  logic                           bus_rd,
  output logic [31:0]                    bus_rdata,
  // transmit frames
  output logic                           tx_valid,
  output logic [17:0]                    tx_group,
  output logic [63:0]                    tx_data,
  input  logic                           tx_ready,
  // received frames
  input  logic                           rx_valid,
  input  logic [28:0]                    rx_id,
  input  logic [63:0]                    rx_data,
  // local values
  input  logic [3:0][31:0]               uin_val,
  input  logic [31:0]                    motor_speed,
  input  logic [31:0]                    motor_current,
  input  logic [31:0]                    supply_volt,
  input  logic [31:0]                    proc_temp,
  input  logic [CANSP_NUM_ADD-1:0][31:0] addl_data,
  input  logic [31:0]                    pid_out,
  // receive results
  output logic [CANSP_NUM_RX-1:0][31:0]  rx_value,
  output logic [CANSP_NUM_RX-1:0]        rx_state,
  output logic [CANSP_NUM_RX-1:0]        rx_link_loss
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    cansp_cfg_t                       cfg;
    logic [31:0]                      rdata;
    logic [15:0]                      tick_cnt;
    logic [11:0]                      hold_cnt;
    logic                             hold_done;
    logic [1:0][15:0]                 per_cnt;
    logic [1:0]                       pend;
    logic                             tx_valid;
    logic [17:0]                      tx_group;
    logic [63:0]                      tx_data;
    logic [CANSP_NUM_RX-1:0][31:0]    rx_val;
    logic [CANSP_NUM_RX-1:0][15:0]    rx_age;
    logic [CANSP_NUM_RX-1:0]          rx_fault;
    logic [CANSP_NUM_RX-1:0]          rx_dig;
  } cansp_st_s;

  cansp_st_s                 st_reg;
  cansp_st_s                 st_next;
  cansp_src_s                src;
  logic [CANSP_NUM_SIG-1:0][63:0] sig_bits;
  logic                      tick;
  logic [31:0]               status_word;

  // ---------------------------------------------------------------
  // sources and transmit signal packers
  // ---------------------------------------------------------------
  // one pool feeds every packer, so any block may take any source
  always_comb begin : src_pool
    src         = '0;
    src.rx      = st_reg.rx_val;
    src.uin     = uin_val;
    src.speed   = motor_speed;
    src.current = motor_current;
    src.supply  = supply_volt;
    src.temp    = proc_temp;
    src.tmo     = |st_reg.rx_fault;
    src.addl    = addl_data;
    src.pid     = pid_out;
    for (int k = 0; k < CANSP_NUM_K; k++) begin
      src.konst[k] = st_reg.cfg[CANSP_IDX_K_BASE + k];
    end
  end

  genvar gk;
  for (gk = 0; gk < CANSP_NUM_SIG; gk++) begin : g_sig
    cansp_sig_pack u_pack (
      .src        (src),
      .cfg_word   (st_reg.cfg[CANSP_IDX_SIG_BASE + 2 * gk]),
      .scale_word (st_reg.cfg[CANSP_IDX_SIG_BASE + 2 * gk + 1]),
      .field_bits (sig_bits[gk])
    );
  end

  assign tick        = (st_reg.tick_cnt == 16'(MS_CYCLES - 1));
  assign status_word = {22'h0, st_reg.tx_valid, st_reg.hold_done, st_reg.rx_dig, st_reg.rx_fault};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin : next_state
    logic [5:0]         widx;
    logic               shared;
    logic [1:0][15:0]   rate;
    logic [1:0][63:0]   msg_data;
    logic               pick;
    logic [5:0]         base;
    logic [31:0]        rcfg;
    logic [5:0]         rsize;
    logic [31:0]        rmask;
    logic [31:0]        raw;
    logic signed [49:0] rsc;
    logic signed [49:0] rmin;
    logic signed [49:0] rmax;
    logic               hit;
    widx     = bus_addr[7:2];
    shared   = 1'b0;
    rate     = '0;
    msg_data = '0;
    pick     = 1'b0;
    base     = '0;
    rcfg     = '0;
    rsize    = '0;
    rmask    = '0;
    raw      = '0;
    rsc      = '0;
    rmin     = '0;
    rmax     = '0;
    hit      = 1'b0;
    st_next  = st_reg;

    // register port: read data only in the cycle after the strobe
    st_next.rdata = '0;
    if (bus_rd) begin
      if (widx == CANSP_IDX_STATUS) begin
        st_next.rdata = status_word;
      end else if (widx >= CANSP_IDX_RX_BASE && widx[2:0] == CANSP_RX_VAL) begin
        st_next.rdata = st_reg.rx_val[widx[4:3]];
      end else if (cansp_writable(widx)) begin
        st_next.rdata = st_reg.cfg[widx];
      end
    end
    if (bus_wr && cansp_writable(widx)) begin
      st_next.cfg[widx] = bus_wdata;
    end

    // millisecond tick and power-up hold-off
    st_next.tick_cnt = tick ? 16'h0000 : st_reg.tick_cnt + 16'h0001;
    if (tick && !st_reg.hold_done) begin
      st_next.hold_cnt  = st_reg.hold_cnt + 12'h001;
      st_next.hold_done = (st_reg.hold_cnt + 12'h001 == 12'(HOLD_MS));
    end

    // message payloads; a shared group goes out as one bundle
    for (int s = 0; s < CANSP_NUM_SIG; s++) begin
      msg_data[s / CANSP_SIG_PER] = msg_data[s / CANSP_SIG_PER] | sig_bits[s];
    end
    shared  = (st_reg.cfg[CANSP_IDX_TX_GRP0][17:0] == st_reg.cfg[CANSP_IDX_TX_GRP1][17:0]);
    rate[0] = st_reg.cfg[CANSP_IDX_TX_PER0][15:0];
    rate[1] = st_reg.cfg[CANSP_IDX_TX_PER1][15:0];
    if (shared) begin
      if (rate[0] == 16'h0000) rate[0] = rate[1];
      rate[1]     = 16'h0000;
      msg_data[0] = msg_data[0] | msg_data[1];
    end

    // frame hand-off: hold until taken, then serve a pending message
    if (st_reg.tx_valid && tx_ready) st_next.tx_valid = 1'b0;
    if ((!st_reg.tx_valid || tx_ready) && (|st_reg.pend)) begin
      pick                 = !st_reg.pend[0];
      st_next.tx_valid     = 1'b1;
      st_next.tx_data      = msg_data[pick];
      st_next.tx_group     = st_reg.cfg[pick ? CANSP_IDX_TX_GRP1 : CANSP_IDX_TX_GRP0][17:0];
      st_next.pend[pick]   = 1'b0;
    end

    // repetition timers; a new expiry wins over the hand-off clear
    for (int m = 0; m < CANSP_NUM_TX; m++) begin
      if (!st_reg.hold_done || rate[m] == 16'h0000) begin
        st_next.per_cnt[m] = '0;
        st_next.pend[m]    = 1'b0;
      end else if (tick) begin
        if (st_reg.per_cnt[m] + 16'h0001 >= rate[m]) begin
          st_next.per_cnt[m] = '0;
          st_next.pend[m]    = 1'b1;
        end else begin
          st_next.per_cnt[m] = st_reg.per_cnt[m] + 16'h0001;
        end
      end
    end

    // receive slots
    for (int j = 0; j < CANSP_NUM_RX; j++) begin
      base  = 6'(CANSP_IDX_RX_BASE + 8 * j);
      rcfg  = st_reg.cfg[base + CANSP_RX_CFG];
      rsize = (rcfg[CANSP_F_SIZE +: 6] >= CANSP_FIELD_MAX) ? CANSP_FIELD_MAX :
              rcfg[CANSP_F_SIZE +: 6];
      rmask = (rsize == CANSP_FIELD_MAX) ? 32'hFFFF_FFFF :
              32'((33'h0_0000_0001 << rsize) - 33'h0_0000_0001);
      raw   = 32'(rx_data >> rcfg[CANSP_F_POS +: 6]) & rmask;
      rsc   = (($signed({1'b0, raw}) *
                $signed({1'b0, st_reg.cfg[base + CANSP_RX_SCALE][CANSP_F_RES +: 16]}))
               >>> CANSP_RES_FRAC) +
              50'($signed(st_reg.cfg[base + CANSP_RX_SCALE][CANSP_F_OFF +: 16]));
      rmin  = 50'($signed(st_reg.cfg[base + CANSP_RX_LIM][CANSP_F_MIN +: 16]));
      rmax  = 50'($signed(st_reg.cfg[base + CANSP_RX_LIM][CANSP_F_MAX +: 16]));
      hit   = rx_valid && rcfg[CANSP_F_EN] &&
              (rx_id == st_reg.cfg[base + CANSP_RX_ID][28:0]);
      if (!rcfg[CANSP_F_EN]) begin
        st_next.rx_val[j]   = '0;
        st_next.rx_age[j]   = '0;
        st_next.rx_fault[j] = 1'b0;
        st_next.rx_dig[j]   = 1'b0;
      end else if (hit) begin
        // thresholds act on the scaled value; max is checked first
        if (rsc >= rmax) st_next.rx_dig[j] = 1'b1;
        else if (rsc <= rmin) st_next.rx_dig[j] = 1'b0;
        if (rsc < rmin) rsc = rmin;
        if (rsc > rmax) rsc = rmax;
        st_next.rx_val[j]   = rsc[31:0];
        st_next.rx_age[j]   = '0;
        st_next.rx_fault[j] = 1'b0;
      end else if (st_reg.cfg[base + CANSP_RX_TMO][15:0] == 16'h0000) begin
        st_next.rx_age[j]   = '0;
        st_next.rx_fault[j] = 1'b0;
      end else if (tick && !st_reg.rx_fault[j]) begin
        st_next.rx_age[j] = st_reg.rx_age[j] + 16'h0001;
        if (st_reg.rx_age[j] + 16'h0001 >= st_reg.cfg[base + CANSP_RX_TMO][15:0]) begin
          st_next.rx_fault[j] = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // config words reset to zero, which leaves every slot and message off
  always_ff @(posedge mclk) begin : regs
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata    = st_reg.rdata;
  assign tx_valid     = st_reg.tx_valid;
  assign tx_group     = st_reg.tx_group;
  assign tx_data      = st_reg.tx_data;
  assign rx_value     = st_reg.rx_val;
  assign rx_state     = st_reg.rx_dig;
  assign rx_link_loss = st_reg.rx_fault;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_tx_wait;
    st_reg.tx_valid && !tx_ready;
  endsequence

  sequence s_tx_held;
    st_reg.tx_valid && $stable(st_reg.tx_data) && $stable(st_reg.tx_group);
  endsequence

  chk_tx_holdoff: assert property (!st_reg.hold_done |-> !st_reg.tx_valid)
    else $error("frame offered before hold-off ended");

  chk_tx_frame_held: assert property (s_tx_wait |=> s_tx_held)
    else $error("offered frame changed before it was taken");

  // a frame already pending when both periods drop to zero may still go out once
  logic rate_zero;
  assign rate_zero = (st_reg.cfg[CANSP_IDX_TX_PER0][15:0] == 16'h0000) &&
                     (st_reg.cfg[CANSP_IDX_TX_PER1][15:0] == 16'h0000);

  chk_tx_both_off: assert property (
    ($past(rate_zero, 2) && $past(rate_zero)) |-> !$rose(st_reg.tx_valid))
    else $error("frame sent with both periods zero");

  for (gk = 0; gk < CANSP_NUM_RX; gk++) begin : g_chk
    localparam logic [5:0] B = 6'(CANSP_IDX_RX_BASE + 8 * gk);
    chk_rx_idle_off: assert property (
      !st_reg.cfg[B][CANSP_F_EN] |=> (st_reg.rx_fault[gk] == 1'b0 && st_reg.rx_val[gk] == '0))
      else $error("disabled slot shows activity");
    chk_rx_tmo_zero: assert property (
      (st_reg.cfg[B + 3][15:0] == 16'h0000) [*2] |-> !st_reg.rx_fault[gk])
      else $error("link loss with supervision off");
    chk_rx_loss_rise: assert property ($rose(st_reg.rx_fault[gk]) |->
      ($past(tick) && $past(st_reg.cfg[B][CANSP_F_EN]) &&
       ($past(st_reg.rx_age[gk]) + 16'h0001 >= $past(st_reg.cfg[B + 3][15:0]))))
      else $error("link loss raised without timeout");
    chk_rx_val_bound: assert property (
      $changed(st_reg.rx_val[gk]) && $stable(st_reg.cfg[B + 4])
      && $past(st_reg.cfg[B][CANSP_F_EN]) |->
      ($signed(st_reg.rx_val[gk]) >= 32'($signed(st_reg.cfg[B + 4][15:0])) &&
       $signed(st_reg.rx_val[gk]) <= 32'($signed(st_reg.cfg[B + 4][31:16]))))
      else $error("received value outside limits");
    chk_rx_on_level: assert property ($rose(st_reg.rx_dig[gk]) |->
      $signed(st_reg.rx_val[gk]) >= 32'($signed($past(st_reg.cfg[B + 4][31:16]))))
      else $error("on state below on threshold");
  end

  for (gk = 0; gk < CANSP_NUM_SIG; gk++) begin : g_chk_sig
    chk_sig_unused: assert property (
      (st_reg.cfg[CANSP_IDX_SIG_BASE + 2 * gk][3:0] == 4'h0) |-> (sig_bits[gk] == 64'h0))
      else $error("unused signal contributes bits");
  end

endmodule : cansp_frame_map

// >>> cansp_far_node.sv
// far-side node model: frame sink with optional stalls, frame source on command
`timescale 1ns/1ps
module cansp_far_node (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // commands from the bench
  input  wire logic        slow,
  input  wire logic        send,
  input  wire logic [28:0] s_id,
  input  wire logic [63:0] s_data,
  // link side
  output logic             tx_ready,
  output logic             rx_valid,
  output logic [28:0]      rx_id,
  output logic [63:0]      rx_data
);
  logic [1:0] cnt;
  // idle lines toggle so a stale frame can never pass for a fresh one
  always @(posedge mclk) begin
    cnt      <= rst ? 2'h0 : cnt + 2'h1;
    tx_ready <= !rst && (!slow || cnt == 2'h3);
    rx_valid <= !rst && send;
    rx_id    <= rst ? 29'h0 : send ? s_id : ~rx_id;
    rx_data  <= rst ? 64'h0 : send ? s_data : ~rx_data;
  end
endmodule : cansp_far_node

// >>> tb.sv
// testbench: receive mapping, link loss and transmit packing against a reference
`timescale 1ns/1ps
module tb;
  import cansp_pkg::*;
  logic              mclk, rst, bus_wr, bus_rd, tx_valid, tx_ready, rx_valid, slow, send;
  logic [7:0]        bus_addr;
  logic [17:0]       tx_group;
  logic [28:0]       rx_id, s_id;
  logic [31:0]       bus_wdata, bus_rdata, seed, u, spd, cur, sup, tmp, pid;
  logic [63:0]       tx_data, rx_data, s_data, d;
  logic [3:0]        rx_state, rx_link_loss;
  logic [3:0][31:0]  uin_val, rx_value;
  logic [15:0][31:0] addl_data;
  int                failures, n_compared, v, st;
  // address and data of every setup write; fields never overlap
  // signal 3 carries the link-loss flag as one bit at bit 0
  logic [39:0] cfg [16] = '{
    {8'h80, 32'h0140_2001}, {8'h84, 32'h18FF_0A01}, {8'h88, 32'h0100_FFF6},
    {8'h8C, 32'h0000_0003}, {8'h90, 32'h00C8_0000}, {8'hA0, 32'h0000_0001},
    {8'h10, 32'h00B0_1023}, {8'h14, 32'h0100_0000}, {8'h18, 32'h03C0_2012},
    {8'h1C, 32'h0200_0005}, {8'h20, 32'h0000_2000}, {8'h04, 32'h0000_FF00},
    {8'h28, 32'h0000_0418}, {8'h2C, 32'h0100_0000}, {8'hFC, 32'hFFFF_FFFF},
    {8'h00, 32'h0000_0001}};
  cansp_frame_map #(.MS_CYCLES(4), .HOLD_MS(2)) dut (.mclk, .rst, .bus_addr, .bus_wdata,
    .bus_wr, .bus_rd, .bus_rdata, .tx_valid, .tx_group, .tx_data, .tx_ready, .rx_valid,
    .rx_id, .rx_data, .uin_val, .motor_speed(spd), .motor_current(cur), .supply_volt(sup),
    .proc_temp(tmp), .addl_data, .pid_out(pid), .rx_value, .rx_state, .rx_link_loss);
  cansp_far_node far (.mclk, .rst, .slow, .send, .s_id, .s_data, .tx_ready, .rx_valid,
    .rx_id, .rx_data);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (e !== g) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one write or one read; read data stand only in the cycle after the strobe
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] x);
    @(posedge mclk);
    bus_addr  <= a;
    bus_wdata <= x;
    bus_wr    <= w;
    bus_rd    <= !w;
    @(posedge mclk);
    {bus_wr, bus_rd} <= 2'h0;
    #1 if (!w) chk("bus_rdata", x, bus_rdata);
  endtask : bus
  task automatic close_out();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  initial begin
    seed = 32'h854E;
    {failures, n_compared, st} = '0;
    rst = 1'b1;
    {slow, send, bus_wr, bus_rd, bus_addr, bus_wdata, s_data} = '0;
    s_id = 29'h18FF_0A01;
    {spd, cur, sup, tmp, pid} = {xs(), xs(), xs(), xs(), xs()};
    uin_val = {4{xs()}};
    addl_data = {16{xs()}};
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk("rx_value", 64'h0, {rx_value[1], rx_value[0]});
    foreach (cfg[i]) bus(1'b1, cfg[i][39:32], cfg[i][31:0]);
    bus(1'b0, 8'hFC, 32'h0);
    bus(1'b0, 8'h8C, 32'h3);
    for (int i = 0; i < 6; i++) begin
      d = {xs(), xs()};
      if (i < 2) d[27:20] = i ? 8'h05 : 8'hFF;
      @(posedge mclk);
      {s_data, send} <= {d, 1'b1};
      @(posedge mclk);
      send <= 1'b0;
      repeat (2) @(negedge mclk);
      v = int'(d[27:20]) - 10;
      st = v >= 200 ? 1 : v <= 0 ? 0 : st;
      chk("rx_value", v < 0 ? 0 : v > 200 ? 200 : v, rx_value[0]);
      chk("rx_state", st, rx_state[0]);
      chk("rx_link_loss", 0, rx_link_loss[0]);
    end
    for (v = 0; v < 40 && rx_link_loss[0] !== 1'b1; v++) @(negedge mclk);
    chk("rx_link_loss", 1, rx_link_loss[0]);
    chk("rx_link_loss", 0, rx_link_loss[1]);
    @(posedge mclk);
    slow <= 1'b1;
    // the first frame after a source change may predate it, so only the second counts
    for (int i = 0; i < 8; i++) begin
      u = i < 2 ? 32'hFF * i : xs() & 32'hFF;
      uin_val[0] <= u;
      repeat (2) begin
        v = 0;
        do begin
          @(negedge mclk);
          v++;
        end while (v < 200 && (tx_valid & tx_ready) !== 1'b1);
        if (v == 200) failures++;
        if (v == 200) close_out();
        chk("tx_group", 64'h0FF00, tx_group);
        d = tx_data;
        @(posedge mclk);
      end
      v = (int'(u) - 5) * 2;
      v = v < 0 ? 0 : v > 255 ? 255 : v;
      // bit 0 is the link-loss flag of any slot, here set by slot 0, which stays set after its frames stop
      chk("tx_data", 64'h801 | (64'(v & 15) << 60), d);
    end
    close_out();
  end
endmodule : tb
